// ==== tb.sv ====
// Self-checking bench for the watchpoint pair and the debug control register.
`timescale 1ns/1ns
module tb;
  import wicdc_pkg::*;
  logic        sys_clk, reset, testResetN, scanIn, scanShift, scanCapture, scanUpdate, scanOut;
  logic        fetchValid, fetchIsaState, fetchPrivilege, coreDebugAck, externalDebugReq;
  logic        irqIn, fiqIn, instructionBreak, debugAckOut, debugReqOut, irqToCore, fiqToCore;
  logic        monitorModeEnable, comparatorsDisabled;
  logic [1:0]  externalCondition, grp;
  logic [31:0] fetchAddr, fetchData, dv, rnd;
  logic [31:0] av [2];
  logic [31:0] am [2];
  logic [8:0]  cv [2];
  logic [7:0]  cm [2];
  logic [5:0]  dc;
  logic        latch1, expBrk, expIrq, expFiq, expAck, expReq, checkOn;
  int          error_cnt, checked, seed;

  wicdc_scan_host host_u (.sys_clk(sys_clk), .scanIn(scanIn), .scanShift(scanShift),
    .scanCapture(scanCapture), .scanUpdate(scanUpdate), .scanOut(scanOut));

  wicdc_top dut_u (.sys_clk(sys_clk), .reset(reset), .testResetN(testResetN), .scanIn(scanIn),
    .scanShift(scanShift), .scanCapture(scanCapture), .scanUpdate(scanUpdate),
    .scanOut(scanOut), .fetchValid(fetchValid), .fetchAddr(fetchAddr), .fetchData(fetchData),
    .fetchIsaState(fetchIsaState), .fetchPrivilege(fetchPrivilege),
    .externalCondition(externalCondition), .coreDebugAck(coreDebugAck),
    .externalDebugReq(externalDebugReq), .irqIn(irqIn), .fiqIn(fiqIn),
    .instructionBreak(instructionBreak), .debugAckOut(debugAckOut), .debugReqOut(debugReqOut),
    .irqToCore(irqToCore), .fiqToCore(fiqToCore), .monitorModeEnable(monitorModeEnable),
    .comparatorsDisabled(comparatorsDisabled));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chkBit(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %0b seen %0b", name, exp, got);
    end
  endtask : chkBit

  task automatic chkWord(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chkWord

  task automatic readChk(input logic [4:0] addr, input logic [31:0] exp);
    logic [31:0] data;
    host_u.scanRead(addr, data);
    chkWord($sformatf("register %h", addr), exp, data);
  endtask : readChk

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  // Reference model: results are compared one edge after the fetch that caused them.
  always @(posedge sys_clk) begin
    logic       a0, a1, c0, c1, d;
    logic [7:0] v0, v1;
    if (checkOn) begin
      chkBit("instructionBreak", expBrk, instructionBreak);
      chkBit("irqToCore", expIrq, irqToCore);
      chkBit("fiqToCore", expFiq, fiqToCore);
      chkBit("debugAckOut", expAck, debugAckOut);
      chkBit("debugReqOut", expReq, debugReqOut);
      chkBit("comparatorsDisabled", dc[5], comparatorsDisabled);
      chkBit("monitorModeEnable", dc[4], monitorModeEnable);
    end
    d  = &(~(dv ^ fetchData));
    a1 = fetchValid && (&(am[1] | ~(av[1] ^ fetchAddr)));
    a0 = fetchValid && (&(am[0] | ~(av[0] ^ fetchAddr)));
    v1 = {2'b00, externalCondition[1], fetchPrivilege, 2'b00, fetchIsaState, 1'b0};
    v0 = {a1, latch1, externalCondition[0], fetchPrivilege, 2'b00, fetchIsaState, 1'b0};
    c1 = &((cm[1] & 8'hf7) | ~(cv[1][7:0] ^ v1));
    c0 = &((cm[0] & 8'hf7) | ~(cv[0][7:0] ^ v0));
    expBrk = !dc[5] && ((a0 && c0 && d && cv[0][8]) || (a1 && c1 && d && cv[1][8]));
    if (!testResetN) latch1 = 1'b0;
    else if (a1 && c1) latch1 = d;
    expIrq = irqIn & ~(coreDebugAck | dc[2]);
    expFiq = fiqIn & ~(coreDebugAck | dc[2]);
    expAck = coreDebugAck | dc[0];
    expReq = externalDebugReq | dc[1];
  end

  initial begin
    #(20 * 40000);
    error_cnt++;
    $display("Watchdog expired before the tests ended");
    final_report;
  end

  initial begin
    seed = 45891;
    {reset, testResetN, checkOn, latch1} = 4'b1100;
    {fetchValid, fetchIsaState, fetchPrivilege, coreDebugAck, externalDebugReq} = 5'h00;
    {irqIn, fiqIn, externalCondition, fetchAddr, fetchData} = 68'h0;
    dc = 6'h10;
    repeat (8) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    chkBit("monitorModeEnable", 1'b1, monitorModeEnable);
    readChk(ADDR_DBG_CTRL, 32'h00000010);
    for (int r = 0; r < 4; r++) begin
      rnd   = $random(seed);
      dv    = $random(seed);
      dc    = rnd[21:16];
      dc[5] = (r == 3);
      for (int w = 0; w < 2; w++) begin
        rnd   = $random(seed);
        av[w] = $random(seed);
        am[w] = 32'h0000000f;
        cv[w] = {rnd[24:20], rnd[25] & (r == 2), 1'b0, rnd[17:16]};
        cm[w] = rnd[7:0] | rnd[15:8] | 8'h01 | ((w == 1 || dc[5]) ? 8'hc0 : 8'h00);
        grp   = (w == 1) ? WP1_GROUP : WP0_GROUP;
        host_u.scanWrite({grp, WP_ADDR_VALUE}, av[w]);
        host_u.scanWrite({grp, WP_ADDR_MASK}, am[w]);
        host_u.scanWrite({grp, WP_DATA_VALUE}, dv);
        host_u.scanWrite({grp, WP_DATA_MASK}, 32'h00000000);
        host_u.scanWrite({grp, WP_CTRL_VALUE}, {23'h000000, cv[w]});
        host_u.scanWrite({grp, WP_CTRL_MASK}, {24'h000000, cm[w]});
      end
      latch1 = 1'b0;
      host_u.scanWrite(ADDR_DBG_CTRL, {26'h0000000, dc});
      readChk(ADDR_DBG_CTRL, {26'h0000000, dc & 6'h37});
      readChk({WP1_GROUP, WP_CTRL_VALUE}, {23'h000000, cv[1]});
      host_u.scanWrite(5'h07, rnd);
      readChk(5'h07, 32'h00000000);
      repeat (3) @(posedge sys_clk);
      #1;
      checkOn = 1'b1;
      repeat (200) begin
        @(posedge sys_clk) #1;
        rnd = $random(seed);
        {fetchIsaState, fetchPrivilege, externalCondition, irqIn, fiqIn} = rnd[5:0];
        {coreDebugAck, externalDebugReq, fetchValid} = rnd[8:6];
        testResetN = |rnd[11:9];
        fetchAddr  = av[rnd[12]] ^ {27'h0000000, rnd[17:13]};
        fetchData  = dv ^ {31'h00000000, rnd[18]};
      end
      @(posedge sys_clk) #1;
      fetchValid = 1'b0;
      testResetN = 1'b1;
      @(posedge sys_clk) #1;
      checkOn = 1'b0;
      $display("Round %0d of fetch and register tests done", r);
    end
    final_report;
  end
endmodule : tb

// ==== wicdc_pkg.sv ====
// Constants, register map and compare helper shared by the debug watchpoint block.
package wicdc_pkg;

  // Scan word layout: data field, address field, read/write bit.
  localparam int SCAN_W      = 38;
  localparam int SCAN_DATA_W = 32;
  localparam int SCAN_ADDR_W = 5;
  localparam int SCAN_ADDR_LO = 32;
  localparam int SCAN_RW_BIT = 37;

  // Register addresses on the scan chain.
  localparam logic [4:0] ADDR_DBG_CTRL = 5'h00;
  localparam logic [1:0] WP0_GROUP     = 2'h1;
  localparam logic [1:0] WP1_GROUP     = 2'h2;
  localparam logic [2:0] WP_ADDR_VALUE = 3'h0;
  localparam logic [2:0] WP_ADDR_MASK  = 3'h1;
  localparam logic [2:0] WP_DATA_VALUE = 3'h2;
  localparam logic [2:0] WP_DATA_MASK  = 3'h3;
  localparam logic [2:0] WP_CTRL_VALUE = 3'h4;
  localparam logic [2:0] WP_CTRL_MASK  = 3'h5;

  // Watchpoint control field, instruction comparison format.
  localparam int CV_W       = 9;
  localparam int CM_W       = 8;
  localparam int CTL_ISA    = 1;
  localparam int CTL_FORMAT = 3;
  localparam int CTL_PRIV   = 4;
  localparam int CTL_EXT    = 5;
  localparam int CTL_CHAIN  = 6;
  localparam int CTL_RANGE  = 7;
  localparam int CTL_ENABLE = 8;
  localparam logic [7:0] CTL_UNMASKABLE = 8'h08;

  // Debug control register.
  localparam int DC_W       = 6;
  localparam int DC_ACK     = 0;
  localparam int DC_REQ     = 1;
  localparam int DC_INHIBIT = 2;
  localparam int DC_SBZ     = 3;
  localparam int DC_MONITOR = 4;
  localparam int DC_DISABLE = 5;
  localparam logic [5:0] DC_RESET    = 6'h10;
  localparam logic [5:0] DC_WRITABLE = 6'h37;

  // A word matches when every unmasked bit equals the value bit.
  function automatic logic maskedMatch(input logic [31:0] value, input logic [31:0] mask,
                                       input logic [31:0] actual);
    maskedMatch = &(mask | ~(value ^ actual));
  endfunction : maskedMatch

endpackage : wicdc_pkg

// ==== wicdc_scan_host.sv ====
// Debug host model that reaches the registers through the serial scan word.
`timescale 1ns/1ns
module wicdc_scan_host (
  // Clock.
  input  wire logic sys_clk,
  // Scan chain towards the block.
  output logic      scanIn,
  output logic      scanShift,
  output logic      scanCapture,
  output logic      scanUpdate,
  input  wire logic scanOut
);
  initial begin
    scanIn      = 1'b0;
    scanShift   = 1'b0;
    scanCapture = 1'b0;
    scanUpdate  = 1'b0;
  end

  // Shifts a whole word, data bit 0 first and the direction bit last, then updates.
  task automatic shiftWord(input logic [37:0] word);
    for (int i = 0; i < 38; i++) begin
      @(posedge sys_clk) #1;
      scanShift = 1'b1;
      scanIn    = word[i];
    end
    @(posedge sys_clk) #1;
    scanShift  = 1'b0;
    scanIn     = ~scanIn;
    scanUpdate = 1'b1;
    @(posedge sys_clk) #1;
    scanUpdate = 1'b0;
  endtask : shiftWord

  task automatic scanWrite(input logic [4:0] addr, input logic [31:0] data);
    shiftWord({1'b1, addr, data});
  endtask : scanWrite

  // A read needs the address update first, then a capture, then the data shifted out.
  task automatic scanRead(input logic [4:0] addr, output logic [31:0] data);
    shiftWord({1'b0, addr, 32'h00000000});
    @(posedge sys_clk) #1;
    scanCapture = 1'b1;
    @(posedge sys_clk) #1;
    scanCapture = 1'b0;
    for (int i = 0; i < 32; i++) begin
      data[i]   = scanOut;
      scanShift = 1'b1;
      @(posedge sys_clk) #1;
    end
    scanShift = 1'b0;
  endtask : scanRead
endmodule : wicdc_scan_host

// ==== wicdc_top.sv ====
// Debug watchpoint pair, debug control register and scan register access.
//
// What this block does
// - Control bit 1 compares fetch instruction-set state.
// - Control bit 4 compares fetch privilege.
// - Bit 5 compares per-watchpoint external condition.
// - Bit 6 compares chain; unit 1 feeds 0.
// - Chain latch: address/control enables, data stores.
// - Chain latch cleared by control write, test reset.
// - Bit 7 compares range; unit 1 address feeds 0.
// - Break asserted only when enable bit set.
// - Debug control register is six bits.
// - Read/write bit high writes, low reads.
// - Disable, monitor, zero, inhibit, request, acknowledge bits.
// - Mask bit one ignores the value bit, except the control format bit.
// - Format bit zero compares instruction buses.
// - Access by 38-bit data, address, read/write word.
// - Interrupts blocked in debug state or inhibited.
`timescale 1ns/1ns
module wicdc_top
  import wicdc_pkg::*;
(
  // Clock and resets.
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        testResetN,
  // Scan chain from the debug host.
  input  wire logic        scanIn,
  input  wire logic        scanShift,
  input  wire logic        scanCapture,
  input  wire logic        scanUpdate,
  output logic             scanOut,
  // Instruction fetch state from the core.
  input  wire logic        fetchValid,
  input  wire logic [31:0] fetchAddr,
  input  wire logic [31:0] fetchData,
  input  wire logic        fetchIsaState,
  input  wire logic        fetchPrivilege,
  input  wire logic [1:0]  externalCondition,
  // Core debug and interrupt signals.
  input  wire logic        coreDebugAck,
  input  wire logic        externalDebugReq,
  input  wire logic        irqIn,
  input  wire logic        fiqIn,
  // Results towards core and system.
  output logic             instructionBreak,
  output logic             debugAckOut,
  output logic             debugReqOut,
  output logic             irqToCore,
  output logic             fiqToCore,
  output logic             monitorModeEnable,
  output logic             comparatorsDisabled
);

  typedef struct packed {
    logic [SCAN_W-1:0]     shiftReg;
    logic [4:0]            readAddr;
    logic [1:0][31:0]      addrValue;
    logic [1:0][31:0]      addrMask;
    logic [1:0][31:0]      dataValue;
    logic [1:0][31:0]      dataMask;
    logic [1:0][CV_W-1:0]  ctrlValue;
    logic [1:0][CM_W-1:0]  ctrlMask;
    logic [DC_W-1:0]       debugCtrl;
    logic                  reqForce;
    logic                  scanOut;
    logic                  brk;
    logic                  ackOut;
    logic                  reqOut;
    logic                  irqOut;
    logic                  fiqOut;
  } wicdc_state_t;

  wicdc_state_t st;
  wicdc_state_t next_st;
  logic         writeEn;
  logic [4:0]   regAddr;
  logic [31:0]  wrData;
  logic [31:0]  readData;
  logic [1:0]   ctrlWrite;
  logic [1:0]   addrMatch;
  logic [1:0]   breakHit;
  logic [1:0]   link_output_latch;
  logic         wpSel;
  logic         wpValid;
  logic         rdSel;
  logic         rdValid;
  logic         blockIrq;

  always_comb begin
    writeEn  = scanUpdate & st.shiftReg[SCAN_RW_BIT];
    regAddr  = st.shiftReg[SCAN_RW_BIT-1:SCAN_ADDR_LO];
    wrData   = st.shiftReg[SCAN_DATA_W-1:0];
    wpSel    = (regAddr[4:3] == WP1_GROUP);
    wpValid  = ((regAddr[4:3] == WP0_GROUP) || (regAddr[4:3] == WP1_GROUP))
               && (regAddr[2:0] <= WP_CTRL_MASK);
    rdSel    = (st.readAddr[4:3] == WP1_GROUP);
    rdValid  = ((st.readAddr[4:3] == WP0_GROUP) || (st.readAddr[4:3] == WP1_GROUP));
    ctrlWrite = 2'b00;
    if (writeEn && wpValid && regAddr[2:0] == WP_CTRL_VALUE) begin
      ctrlWrite[wpSel] = 1'b1;
    end
    // Unmapped addresses read as zero.
    readData = 32'h0000_0000;
    if (st.readAddr == ADDR_DBG_CTRL) begin
      readData[DC_W-1:0] = st.debugCtrl;
    end else if (rdValid) begin
      case (st.readAddr[2:0])
        WP_ADDR_VALUE: readData = st.addrValue[rdSel];
        WP_ADDR_MASK:  readData = st.addrMask[rdSel];
        WP_DATA_VALUE: readData = st.dataValue[rdSel];
        WP_DATA_MASK:  readData = st.dataMask[rdSel];
        WP_CTRL_VALUE: readData[CV_W-1:0] = st.ctrlValue[rdSel];
        WP_CTRL_MASK:  readData[CM_W-1:0] = st.ctrlMask[rdSel];
        default:       readData = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    next_st = st;
    // Update wins over capture, capture over shift, so one word is never half taken.
    if (scanUpdate) begin
      if (writeEn) begin
        if (regAddr == ADDR_DBG_CTRL) begin
          next_st.debugCtrl = wrData[DC_W-1:0] & DC_WRITABLE;
        end else if (wpValid) begin
          case (regAddr[2:0])
            WP_ADDR_VALUE: next_st.addrValue[wpSel] = wrData;
            WP_ADDR_MASK:  next_st.addrMask[wpSel]  = wrData;
            WP_DATA_VALUE: next_st.dataValue[wpSel] = wrData;
            WP_DATA_MASK:  next_st.dataMask[wpSel]  = wrData;
            WP_CTRL_VALUE: next_st.ctrlValue[wpSel] = wrData[CV_W-1:0];
            WP_CTRL_MASK:  next_st.ctrlMask[wpSel]  = wrData[CM_W-1:0];
            default:       next_st.ctrlMask[wpSel]  = st.ctrlMask[wpSel];
          endcase
        end
      end else begin
        next_st.readAddr = regAddr;
      end
    end else if (scanCapture) begin
      next_st.shiftReg = {1'b0, st.readAddr, readData};
    end else if (scanShift) begin
      next_st.shiftReg = {scanIn, st.shiftReg[SCAN_W-1:1]};
    end
    next_st.scanOut = next_st.shiftReg[0];
    // The request force bit is retimed once before it joins the external request.
    next_st.reqForce = st.debugCtrl[DC_REQ];
    next_st.reqOut   = externalDebugReq | st.reqForce;
    next_st.ackOut   = coreDebugAck | st.debugCtrl[DC_ACK];
    blockIrq         = coreDebugAck | st.debugCtrl[DC_INHIBIT];
    next_st.irqOut   = irqIn & ~blockIrq;
    next_st.fiqOut   = fiqIn & ~blockIrq;
    next_st.brk      = |breakHit;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st           <= '0;
      st.debugCtrl <= DC_RESET;
    end else begin
      st <= next_st;
    end
  end

  wicdc_watchpoint #(.WORD_W(32)) u_wp0 (
    .sys_clk           (sys_clk),
    .reset             (reset),
    .testResetN        (testResetN),
    .fetchValid        (fetchValid),
    .fetchAddr         (fetchAddr),
    .fetchData         (fetchData),
    .fetchIsaState     (fetchIsaState),
    .fetchPrivilege    (fetchPrivilege),
    .externalCondition (externalCondition[0]),
    .chainIn           (link_output_latch[1]),
    .rangeIn           (addrMatch[1]),
    .compDisable       (st.debugCtrl[DC_DISABLE]),
    .addrValue         (st.addrValue[0]),
    .addrMask          (st.addrMask[0]),
    .dataValue         (st.dataValue[0]),
    .dataMask          (st.dataMask[0]),
    .ctrlValue         (st.ctrlValue[0]),
    .ctrlMask          (st.ctrlMask[0]),
    .ctrlWrite         (ctrlWrite[0]),
    .addrMatch         (addrMatch[0]),
    .breakHit          (breakHit[0]),
    .link_output_latch          (link_output_latch[0])
  );

  // Unit 1 has no upstream partner, so its chain and range inputs rest low.
  wicdc_watchpoint #(.WORD_W(32)) u_wp1 (
    .sys_clk           (sys_clk),
    .reset             (reset),
    .testResetN        (testResetN),
    .fetchValid        (fetchValid),
    .fetchAddr         (fetchAddr),
    .fetchData         (fetchData),
    .fetchIsaState     (fetchIsaState),
    .fetchPrivilege    (fetchPrivilege),
    .externalCondition (externalCondition[1]),
    .chainIn           (1'b0),
    .rangeIn           (1'b0),
    .compDisable       (st.debugCtrl[DC_DISABLE]),
    .addrValue         (st.addrValue[1]),
    .addrMask          (st.addrMask[1]),
    .dataValue         (st.dataValue[1]),
    .dataMask          (st.dataMask[1]),
    .ctrlValue         (st.ctrlValue[1]),
    .ctrlMask          (st.ctrlMask[1]),
    .ctrlWrite         (ctrlWrite[1]),
    .addrMatch         (addrMatch[1]),
    .breakHit          (breakHit[1]),
    .link_output_latch          (link_output_latch[1])
  );

  always_comb begin
    scanOut             = st.scanOut;
    instructionBreak    = st.brk;
    debugAckOut         = st.ackOut;
    debugReqOut         = st.reqOut;
    irqToCore           = st.irqOut;
    fiqToCore           = st.fiqOut;
    monitorModeEnable   = st.debugCtrl[DC_MONITOR];
    comparatorsDisabled = st.debugCtrl[DC_DISABLE];
  end

  default clocking topClk @(posedge sys_clk); endclocking
  default disable iff (reset);

  dc_write_a: assert property (scanUpdate && st.shiftReg[SCAN_RW_BIT]
                               && st.shiftReg[36:32] == ADDR_DBG_CTRL
                               |=> st.debugCtrl == ($past(st.shiftReg[5:0]) & DC_WRITABLE))
    else $error("debug control write not stored");
  sbz_zero_a: assert property (st.debugCtrl[DC_SBZ] == 1'b0)
    else $error("should-be-zero bit holds one");
  dc_readback_a: assert property (scanCapture && !scanUpdate && st.readAddr == ADDR_DBG_CTRL
                                  |=> st.shiftReg[31:0] == {26'h0, $past(st.debugCtrl)})
    else $error("debug control read returned wrong value");
  irq_block_a: assert property (blockIrq |=> !irqToCore && !fiqToCore)
    else $error("interrupt passed while blocked");
  ack_force_a: assert property (st.debugCtrl[DC_ACK] |=> debugAckOut)
    else $error("forced acknowledge not seen");
  req_force_a: assert property (st.debugCtrl[DC_REQ] ##1 st.debugCtrl[DC_REQ] |=> debugReqOut)
    else $error("forced request not seen");
  break_enable_a: assert property (instructionBreak
                                   |-> $past(st.ctrlValue[0][CTL_ENABLE]
                                             | st.ctrlValue[1][CTL_ENABLE]))
    else $error("break without enable bit");
  disable_cmp_a: assert property (comparatorsDisabled |=> !instructionBreak)
    else $error("break while comparators disabled");
  shift_word_a: assert property (scanShift && !scanUpdate && !scanCapture
                                 |=> st.shiftReg[SCAN_W-1] == $past(scanIn)
                                     && scanOut == $past(st.shiftReg[1]))
    else $error("scan shift misplaced a bit");

  dc_write_c:   cover property (scanUpdate && st.shiftReg[SCAN_RW_BIT] && regAddr == ADDR_DBG_CTRL);
  break_hit_c:  cover property (instructionBreak);
  chain_used_c: cover property (link_output_latch[1] && breakHit[0]);
  readback_c:   cover property (scanUpdate && !st.shiftReg[SCAN_RW_BIT] ##2 scanCapture);

endmodule : wicdc_top

// ==== wicdc_watchpoint.sv ====
// One instruction-fetch watchpoint unit with its chain latch.
`timescale 1ns/1ns
module wicdc_watchpoint
  import wicdc_pkg::*;
#(
  parameter int WORD_W = 32
) (
  // Clock and resets.
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              testResetN,
  // Fetch state from the core.
  input  wire logic              fetchValid,
  input  wire logic [WORD_W-1:0] fetchAddr,
  input  wire logic [WORD_W-1:0] fetchData,
  input  wire logic              fetchIsaState,
  input  wire logic              fetchPrivilege,
  input  wire logic              externalCondition,
  // Coupling with the other unit.
  input  wire logic              chainIn,
  input  wire logic              rangeIn,
  // Programmed values.
  input  wire logic              compDisable,
  input  wire logic [WORD_W-1:0] addrValue,
  input  wire logic [WORD_W-1:0] addrMask,
  input  wire logic [WORD_W-1:0] dataValue,
  input  wire logic [WORD_W-1:0] dataMask,
  input  wire logic [CV_W-1:0]   ctrlValue,
  input  wire logic [CM_W-1:0]   ctrlMask,
  input  wire logic              ctrlWrite,
  // Results.
  output logic                   addrMatch,
  output logic                   breakHit,
  output logic                   link_output_latch
);

  if (WORD_W != 32) begin : g_width_check
    $error("wicdc_watchpoint supports only a 32-bit word");
  end

  typedef struct packed {
    logic chainLatch;
  } wicdc_wp_state_t;

  wicdc_wp_state_t st;
  wicdc_wp_state_t next_st;
  logic [7:0]      actualCtrl;
  logic            addrHit;
  logic            ctrlHit;
  logic            dataHit;
  logic            match;

  always_comb begin
    actualCtrl             = 8'h00;
    actualCtrl[CTL_ISA]    = fetchIsaState;
    actualCtrl[CTL_PRIV]   = fetchPrivilege;
    actualCtrl[CTL_EXT]    = externalCondition;
    actualCtrl[CTL_CHAIN]  = chainIn;
    actualCtrl[CTL_RANGE]  = rangeIn;
    // Format bit cannot be masked, so a data-format setting never matches fetches.
    ctrlHit   = &((ctrlMask & ~CTL_UNMASKABLE) | ~(ctrlValue[7:0] ^ actualCtrl));
    addrHit   = maskedMatch(addrValue, addrMask, fetchAddr);
    dataHit   = maskedMatch(dataValue, dataMask, fetchData);
    match     = fetchValid & ~compDisable & addrHit & ctrlHit & dataHit;
    addrMatch = fetchValid & addrHit;
    breakHit  = match & ctrlValue[CTL_ENABLE];
    next_st   = st;
    if (!testResetN || ctrlWrite) begin
      next_st.chainLatch = 1'b0;
    end else if (fetchValid && addrHit && ctrlHit) begin
      next_st.chainLatch = dataHit;
    end
    link_output_latch = st.chainLatch;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  default clocking wpClk @(posedge sys_clk); endclocking
  default disable iff (reset);

  chain_clear_a: assert property (ctrlWrite |=> !link_output_latch)
    else $error("chain latch not cleared by control write");
  chain_treset_a: assert property (!testResetN |=> !link_output_latch)
    else $error("chain latch not cleared by test reset");
  chain_load_a: assert property (testResetN && !ctrlWrite && fetchValid && addrHit && ctrlHit
                                 |=> link_output_latch == $past(dataHit))
    else $error("chain latch did not take data comparator result");

endmodule : wicdc_watchpoint
